// ===== core/sdc_ctrl.sv
// SDRAM command sequencer: power-up, closed-page access, refresh, power-down, self-refresh.
// Assumes the SDRAM clock is i_sys_clk; commands change on this clock's rising edge.
`timescale 1ns/1ps
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int P_PWRUP_CYC   = sdc_pkg::PWRUP_CYC,
    parameter int P_RAS_MAX_CYC = sdc_pkg::RAS_MAX_CYC,
    parameter int P_SR_BURST    = sdc_pkg::SR_BURST
) (
    // Clock and reset
    input  logic                        i_sys_clk,
    input  logic                        i_sys_rst,
    // User request
    input  logic                        i_req,
    input  logic                        i_req_we,
    input  logic [sdc_pkg::BA_W-1:0]    i_req_bank,
    input  logic [sdc_pkg::ADDR_W-1:0]  i_req_row,
    input  logic [sdc_pkg::COL_W-1:0]   i_req_col,
    output logic                        o_req_ack,
    output logic                        o_init_done,
    // Power control
    input  logic                        i_pd_req,
    input  logic                        i_sr_req,
    // SDRAM pins
    output logic                        o_sd_cke,
    output logic                        o_sd_cs_n,
    output logic                        o_sd_ras_n,
    output logic                        o_sd_cas_n,
    output logic                        o_sd_we_n,
    output logic [sdc_pkg::BA_W-1:0]    o_sd_ba,
    output logic [sdc_pkg::ADDR_W-1:0]  o_sd_addr,
    output logic                        o_sd_dqm
);
    import sdc_pkg::*;

    sdc_state_t          state_ff, nxt_state, ret_ff, nxt_ret;
    logic [TMR_W-1:0]    wait_ff, nxt_wait;
    logic [3:0]          cmd_ff, nxt_cmd;
    logic                cke_ff, nxt_cke;
    logic [BA_W-1:0]     ba_ff, nxt_ba;
    logic [ADDR_W-1:0]   addr_ff, nxt_addr;
    logic                dqm_ff, nxt_dqm;
    logic                ack_ff, nxt_ack;
    logic                init_done_ff, nxt_init_done;
    logic [1:0]          init_cnt_ff, nxt_init_cnt;
    logic [BURST_W-1:0]  burst_ff, nxt_burst;
    logic                sr_want_ff, nxt_sr_want;
    logic                we_ff, nxt_we;
    logic [COL_W-1:0]    col_ff, nxt_col;
    logic                act_go, pre_go, pre_all, ref_go;
    logic [NUM_BANKS-1:0] rc_done, rp_done;
    logic                rrd_done, ras_min_done, ras_max_done;
    logic                ref_pend, ref_urgent;

    function automatic logic bank_hit(input logic [BA_W-1:0] a, input int b);
        return a == BA_W'(b);
    endfunction

    // Per-bank row cycle and precharge timers
    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
        sdc_timer #(.W(TMR_W)) u_rc (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_load    (act_go && bank_hit(nxt_ba, b)),
            .i_cycles  (TMR_W'(RC_CYC)),
            .o_done    (rc_done[b])
        );
        sdc_timer #(.W(TMR_W)) u_rp (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_load    (pre_go && (pre_all || bank_hit(ba_ff, b))),
            .i_cycles  (TMR_W'(RP_CYC)),
            .o_done    (rp_done[b])
        );
    end

    sdc_timer #(.W(TMR_W)) u_rrd (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (act_go),
        .i_cycles  (TMR_W'(RRD_CYC)),
        .o_done    (rrd_done)
    );
    sdc_timer #(.W(TMR_W)) u_ras_min (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (act_go),
        .i_cycles  (TMR_W'(RAS_CYC)),
        .o_done    (ras_min_done)
    );
    sdc_timer #(.W(TMR_W)) u_ras_max (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (act_go),
        .i_cycles  (TMR_W'(P_RAS_MAX_CYC - 1)),
        .o_done    (ras_max_done)
    );
    // No interval counting while the device refreshes itself
    sdc_refresh u_refresh (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_run      (init_done_ff && state_ff != ST_SR),
        .i_ref_done (ref_go),
        .o_pending  (ref_pend),
        .o_urgent   (ref_urgent)
    );

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_ret       = ret_ff;
        nxt_wait      = wait_ff;
        nxt_cmd       = CMD_NOP;
        nxt_cke       = cke_ff;
        nxt_ba        = ba_ff;
        nxt_addr      = addr_ff;
        nxt_dqm       = dqm_ff;
        nxt_ack       = 1'b0;
        nxt_init_done = init_done_ff;
        nxt_init_cnt  = init_cnt_ff;
        nxt_burst     = burst_ff;
        nxt_sr_want   = sr_want_ff;
        nxt_we        = we_ff;
        nxt_col       = col_ff;
        act_go        = 1'b0;
        pre_go        = 1'b0;
        pre_all       = 1'b0;
        ref_go        = 1'b0;
        case (state_ff)
            ST_PWRUP:
            begin
                if (wait_ff == TMR_W'(1))
                begin
                    nxt_cke   = 1'b1;
                    nxt_state = ST_PRE_ALL;
                end
                else
                    nxt_wait = wait_ff - 1'b1;
            end
            ST_PRE_ALL:
            begin
                nxt_cmd   = CMD_PRE;
                nxt_addr  = ADDR_W'(1) << AP_BIT;
                pre_go    = 1'b1;
                pre_all   = 1'b1;
                nxt_wait  = TMR_W'(RP_CYC);
                nxt_ret   = ST_INIT_REF;
                nxt_state = ST_WAIT;
            end
            ST_INIT_REF:
            begin
                nxt_cmd      = CMD_REF;
                nxt_init_cnt = init_cnt_ff + 1'b1;
                nxt_wait     = TMR_W'(RC_CYC);
                nxt_ret      = (nxt_init_cnt == 2'(INIT_REFS)) ? ST_MRS : ST_INIT_REF;
                nxt_state    = ST_WAIT;
            end
            ST_MRS:
            begin
                nxt_cmd       = CMD_MRS;
                nxt_ba        = '0;
                // Burst of one, sequential, latency from the clock period
                nxt_addr      = ADDR_W'(CAS_LAT) << MR_CL_LSB;
                nxt_dqm       = 1'b0;
                nxt_init_done = 1'b1;
                nxt_wait      = TMR_W'(MRD_CYC);
                nxt_ret       = ST_IDLE;
                nxt_state     = ST_WAIT;
            end
            ST_IDLE:
            begin
                if (burst_ff != '0 || ref_urgent || (ref_pend && !i_req))
                begin
                    if (&rp_done)
                    begin
                        nxt_cmd   = CMD_REF;
                        ref_go    = 1'b1;
                        if (burst_ff != '0)
                            nxt_burst = burst_ff - 1'b1;
                        nxt_wait  = TMR_W'(RC_CYC);
                        nxt_ret   = ST_IDLE;
                        nxt_state = ST_WAIT;
                    end
                end
                else if (sr_want_ff)
                begin
                    // Refresh with clock enable low enters self-refresh
                    nxt_cmd     = CMD_REF;
                    nxt_cke     = 1'b0;
                    nxt_sr_want = 1'b0;
                    nxt_wait    = TMR_W'(RAS_CYC);
                    nxt_state   = ST_SR;
                end
                else if (i_sr_req)
                begin
                    nxt_sr_want = 1'b1;
                    nxt_burst   = BURST_W'(P_SR_BURST);
                end
                else if (i_pd_req)
                begin
                    nxt_cke   = 1'b0;
                    nxt_state = ST_PD;
                end
                else if (i_req && rc_done[i_req_bank] && rp_done[i_req_bank] && rrd_done)
                begin
                    // spacing held by the bank and cross-bank timers
                    nxt_cmd   = CMD_ACT;
                    nxt_ba    = i_req_bank;
                    nxt_addr  = i_req_row;
                    nxt_we    = i_req_we;
                    nxt_col   = i_req_col;
                    act_go    = 1'b1;
                    nxt_wait  = TMR_W'(RCD_CYC);
                    nxt_ret   = ST_RW;
                    nxt_state = ST_WAIT;
                end
            end
            ST_RW:
            begin
                nxt_cmd   = we_ff ? CMD_WR : CMD_RD;
                nxt_addr  = ADDR_W'(col_ff);
                nxt_ack   = 1'b1;
                nxt_state = ST_PRE;
            end
            ST_PRE:
            begin
                if (ras_min_done || ras_max_done)
                begin
                    nxt_cmd   = CMD_PRE;
                    nxt_addr  = '0;
                    pre_go    = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_SR:
            begin
                if (wait_ff > TMR_W'(1))
                    nxt_wait = wait_ff - 1'b1;
                else if (!i_sr_req)
                begin
                    nxt_cke   = 1'b1;
                    nxt_burst = BURST_W'(P_SR_BURST);
                    nxt_wait  = TMR_W'(XSR_CYC);
                    nxt_ret   = ST_IDLE;
                    nxt_state = ST_WAIT;
                end
            end
            ST_PD:
            begin
                // Owed refreshes cut power-down short so the interval holds
                if (!i_pd_req || ref_urgent)
                begin
                    nxt_cke   = 1'b1;
                    nxt_wait  = TMR_W'(PDE_CYC);
                    nxt_ret   = ST_IDLE;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (wait_ff == TMR_W'(1))
                    nxt_state = ret_ff;
                else
                    nxt_wait = wait_ff - 1'b1;
            end
            default:
                nxt_state = ST_PWRUP;
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            state_ff     <= ST_PWRUP;
            ret_ff       <= ST_IDLE;
            wait_ff      <= TMR_W'(P_PWRUP_CYC);
            cmd_ff       <= CMD_NOP;
            cke_ff       <= 1'b0;
            ba_ff        <= '0;
            addr_ff      <= '0;
            dqm_ff       <= 1'b1;
            ack_ff       <= 1'b0;
            init_done_ff <= 1'b0;
            init_cnt_ff  <= '0;
            burst_ff     <= '0;
            sr_want_ff   <= 1'b0;
            we_ff        <= 1'b0;
            col_ff       <= '0;
        end
        else
        begin
            state_ff     <= nxt_state;
            ret_ff       <= nxt_ret;
            wait_ff      <= nxt_wait;
            cmd_ff       <= nxt_cmd;
            cke_ff       <= nxt_cke;
            ba_ff        <= nxt_ba;
            addr_ff      <= nxt_addr;
            dqm_ff       <= nxt_dqm;
            ack_ff       <= nxt_ack;
            init_done_ff <= nxt_init_done;
            init_cnt_ff  <= nxt_init_cnt;
            burst_ff     <= nxt_burst;
            sr_want_ff   <= nxt_sr_want;
            we_ff        <= nxt_we;
            col_ff       <= nxt_col;
        end
    end

    assign o_sd_cke    = cke_ff;
    assign o_sd_cs_n   = cmd_ff[3];
    assign o_sd_ras_n  = cmd_ff[2];
    assign o_sd_cas_n  = cmd_ff[1];
    assign o_sd_we_n   = cmd_ff[0];
    assign o_sd_ba     = ba_ff;
    assign o_sd_addr   = addr_ff;
    assign o_sd_dqm    = dqm_ff;
    assign o_req_ack   = ack_ff;
    assign o_init_done = init_done_ff;

    // Helpers for the checks: cycles since the last activate, precharge and mode set seen on the pins
    logic [TMR_W-1:0] since_act_ff, nxt_since_act;
    logic [TMR_W-1:0] since_pre_ff, nxt_since_pre;
    logic [TMR_W-1:0] since_mrs_ff, nxt_since_mrs;
    logic [1:0]       ref_seen_ff, nxt_ref_seen;
    logic             row_open_ff, nxt_row_open;
    // Last precharge target, so the precharge spacing check stays per bank
    logic [BA_W-1:0]  pre_ba_ff, nxt_pre_ba;
    logic             pre_wide_ff, nxt_pre_wide;
    logic [TMR_W-1:0] since_cke_ff, nxt_since_cke;
    logic             sr_seen_ff, nxt_sr_seen;

    always_comb
    begin
        nxt_since_act = (cmd_ff == CMD_ACT) ? '0 : since_act_ff + (since_act_ff != '1);
        nxt_since_pre = (cmd_ff == CMD_PRE) ? '0 : since_pre_ff + (since_pre_ff != '1);
        nxt_since_mrs = (cmd_ff == CMD_MRS) ? '0 : since_mrs_ff + (since_mrs_ff != '1);
        nxt_ref_seen  = ref_seen_ff + ((cmd_ff == CMD_REF) && (ref_seen_ff != '1));
        nxt_row_open  = (cmd_ff == CMD_ACT) ? 1'b1 : ((cmd_ff == CMD_PRE) ? 1'b0 : row_open_ff);
        nxt_pre_ba    = (cmd_ff == CMD_PRE) ? ba_ff : pre_ba_ff;
        nxt_pre_wide  = (cmd_ff == CMD_PRE) ? addr_ff[AP_BIT] : pre_wide_ff;
        nxt_since_cke = !cke_ff ? '0 : since_cke_ff + (since_cke_ff != '1);
        nxt_sr_seen   = (cmd_ff == CMD_REF && !cke_ff) ? 1'b1
                      : ((cmd_ff != CMD_NOP && cke_ff) ? 1'b0 : sr_seen_ff);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            since_act_ff <= '1;
            since_pre_ff <= '1;
            since_mrs_ff <= '1;
            ref_seen_ff  <= '0;
            row_open_ff  <= 1'b0;
            pre_ba_ff    <= '0;
            pre_wide_ff  <= 1'b0;
            since_cke_ff <= '0;
            sr_seen_ff   <= 1'b0;
        end
        else
        begin
            since_act_ff <= nxt_since_act;
            since_pre_ff <= nxt_since_pre;
            since_mrs_ff <= nxt_since_mrs;
            ref_seen_ff  <= nxt_ref_seen;
            row_open_ff  <= nxt_row_open;
            pre_ba_ff    <= nxt_pre_ba;
            pre_wide_ff  <= nxt_pre_wide;
            since_cke_ff <= nxt_since_cke;
            sr_seen_ff   <= nxt_sr_seen;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    a_rc_gap: assert property (cmd_ff == CMD_ACT |-> since_act_ff >= TMR_W'(RC_CYC - 1))
        else $error("activate too soon after activate");
    a_rcd_gap: assert property ((cmd_ff == CMD_RD || cmd_ff == CMD_WR)
        |-> since_act_ff >= TMR_W'(RCD_CYC - 1))
        else $error("column command too soon after activate");
    a_rp_gap: assert property ((cmd_ff == CMD_REF || (cmd_ff == CMD_ACT
        && (pre_wide_ff || ba_ff == pre_ba_ff))) |-> since_pre_ff >= TMR_W'(RP_CYC - 1))
        else $error("activate or refresh too soon after precharge");
    a_rrd_gap: assert property ($rose(cmd_ff == CMD_ACT)
        |-> $past(rrd_done) && since_act_ff >= TMR_W'(RRD_CYC - 1))
        else $error("bank to bank activate too close");
    a_mrd_gap: assert property (cmd_ff != CMD_NOP && cmd_ff != CMD_MRS
        |-> since_mrs_ff >= TMR_W'(MRD_CYC - 1))
        else $error("command too soon after mode set");
    a_ras_min: assert property (cmd_ff == CMD_PRE && row_open_ff
        |-> since_act_ff >= TMR_W'(RAS_CYC - 1))
        else $error("precharge before row active minimum");
    a_ras_max: assert property (row_open_ff |-> since_act_ff < TMR_W'(P_RAS_MAX_CYC))
        else $error("row open past row active maximum");
    a_pde_gap: assert property ($rose(cke_ff) && init_done_ff
        |-> cmd_ff == CMD_NOP ##1 cmd_ff == CMD_NOP)
        else $error("command too soon after clock enable rise");
    a_init_refs: assert property (cmd_ff == CMD_ACT |-> ref_seen_ff >= 2'(INIT_REFS))
        else $error("activate before initial refreshes");
    a_xsr_gap: assert property (cke_ff && sr_seen_ff && cmd_ff != CMD_NOP
        |-> since_cke_ff >= TMR_W'(XSR_CYC))
        else $error("command too soon after self-refresh exit");

    c_read: cover property (cmd_ff == CMD_ACT ##[1:20] cmd_ff == CMD_RD);
    c_write: cover property (cmd_ff == CMD_ACT ##[1:20] cmd_ff == CMD_WR);
    c_refresh: cover property (init_done_ff && cmd_ff == CMD_REF);
    c_power_down: cover property (state_ff == ST_PD ##1 state_ff == ST_WAIT);
endmodule // sdc_ctrl

// ===== core/sdc_pkg.sv
// Constants, command codes and state encoding for the SDRAM command sequencer.
// Assumes a single 100 MHz system clock driving both this logic and the SDRAM clock.
package sdc_pkg;
    // Speed grade: 0 fastest, 1 middle, 2 slowest
    localparam int GRADE            = 2;
    localparam int T_CK_PS          = 10000;
    localparam int T_RC_PS   [3]    = '{55000, 60000, 63000};
    localparam int T_RCD_PS  [3]    = '{15000, 18000, 21000};
    localparam int T_RP_PS   [3]    = '{15000, 18000, 21000};
    localparam int T_RRD_PS  [3]    = '{10000, 12000, 14000};
    localparam int T_MRD_PS  [3]    = '{10000, 12000, 14000};
    localparam int T_RAS_PS  [3]    = '{40000, 42000, 42000};
    localparam int T_RAS_MAX_NS     = 120000;
    localparam int T_CK_CL2_PS      = 10000;
    localparam int T_CK_CL3_PS [3]  = '{5000, 6000, 7000};
    localparam int T_IS_PS          = 1500;
    localparam int T_REFI_NS        = 7800;
    localparam int T_PWRUP_US       = 200;

    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + T_CK_PS - 1) / T_CK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RC_CYC           = cyc_up(T_RC_PS[GRADE]);
    localparam int RCD_CYC          = cyc_up(T_RCD_PS[GRADE]);
    localparam int RP_CYC           = cyc_up(T_RP_PS[GRADE]);
    localparam int RRD_CYC          = cyc_up(T_RRD_PS[GRADE]);
    localparam int MRD_CYC          = cyc_up(T_MRD_PS[GRADE]);
    localparam int RAS_CYC          = cyc_up(T_RAS_PS[GRADE]);
    localparam int RAS_MAX_CYC      = (T_RAS_MAX_NS * 1000) / T_CK_PS;
    localparam int PDE_CYC          = cyc_up(T_IS_PS + T_CK_PS);
    localparam int XSR_CYC          = cyc_up(T_RC_PS[GRADE] + T_IS_PS);
    localparam int REFI_CYC         = (T_REFI_NS * 1000) / T_CK_PS;
    localparam int PWRUP_CYC        = (T_PWRUP_US * 1000000) / T_CK_PS;
    // Slow clock allows the shorter latency
    localparam int CAS_LAT          = (T_CK_PS >= T_CK_CL2_PS) ? 2 : 3;
    localparam int INIT_REFS        = 2;
    localparam int SR_BURST         = 8192;
    localparam int REF_URGENT       = 2;

    localparam int BA_W             = 2;
    localparam int NUM_BANKS        = 4;
    localparam int ADDR_W           = 13;
    localparam int COL_W            = 9;
    localparam int TMR_W            = 16;
    localparam int PEND_W           = 4;
    localparam int BURST_W          = 14;
    localparam int AP_BIT           = 10;
    localparam int MR_CL_LSB        = 4;

    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_MRS  = 4'h0;

    typedef enum logic [9:0] {
        ST_PWRUP    = 10'h001,
        ST_PRE_ALL  = 10'h002,
        ST_INIT_REF = 10'h004,
        ST_MRS      = 10'h008,
        ST_IDLE     = 10'h010,
        ST_RW       = 10'h020,
        ST_PRE      = 10'h040,
        ST_SR       = 10'h080,
        ST_PD       = 10'h100,
        ST_WAIT     = 10'h200
    } sdc_state_t;
endpackage

// ===== core/sdc_timer.sv
// Load-and-expire down counter guarding one command spacing.
// Assumes the load value is at least one cycle.
`timescale 1ns/1ps
module sdc_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  logic         i_sys_clk,
    input  logic         i_sys_rst,
    // Control
    input  logic         i_load,
    input  logic [W-1:0] i_cycles,
    // Status
    output logic         o_done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         done_ff;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (i_load)
            nxt_cnt = i_cycles;
        else if (cnt_ff != '0)
            nxt_cnt = cnt_ff - 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            cnt_ff  <= '0;
            done_ff <= 1'b1;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            done_ff <= (nxt_cnt == '0);
        end
    end

    assign o_done = done_ff;
endmodule // sdc_timer

// ===== core/sdc_refresh.sv
// Refresh interval counter with a count of owed refreshes.
// Assumes i_ref_done pulses once for each refresh command issued.
`timescale 1ns/1ps
module sdc_refresh
    import sdc_pkg::*;
(
    // Clock and reset
    input  logic i_sys_clk,
    input  logic i_sys_rst,
    // Control
    input  logic i_run,
    input  logic i_ref_done,
    // Status
    output logic o_pending,
    output logic o_urgent
);
    logic [TMR_W-1:0]  cnt_ff;
    logic [TMR_W-1:0]  nxt_cnt;
    logic [PEND_W-1:0] pend_ff;
    logic [PEND_W-1:0] nxt_pend;
    logic              tick;

    always_comb
    begin
        tick     = i_run && (cnt_ff == '0);
        nxt_cnt  = tick ? TMR_W'(REFI_CYC - 1) : (i_run ? cnt_ff - 1'b1 : cnt_ff);
        nxt_pend = pend_ff;
        // An expiry in the same cycle as a refresh leaves the owed count unchanged
        if (tick && !i_ref_done && pend_ff != '1)
            nxt_pend = pend_ff + 1'b1;
        else if (!tick && i_ref_done && pend_ff != '0)
            nxt_pend = pend_ff - 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            cnt_ff  <= TMR_W'(REFI_CYC - 1);
            pend_ff <= '0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            pend_ff <= nxt_pend;
        end
    end

    assign o_pending = (pend_ff != '0);
    assign o_urgent  = (pend_ff >= PEND_W'(REF_URGENT));
endmodule // sdc_refresh

// ===== tb/sdc_sdram_model.sv
// Device model that counts command spacing faults seen on the pins.
// Assumes pins change just after rising edges of the shared clock.
`timescale 1ns/1ps
module sdc_sdram_model
    import sdc_pkg::*;
#(
    parameter int P_PWRUP = 50,
    parameter int P_BURST = 4
) (
    // Clock and pins
    input  wire logic        i_clk,
    input  wire logic        i_cke,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [1:0]  i_ba,
    input  wire logic [12:0] i_addr,
    // Fault count
    output int               o_viol
);
    int cyc = 0, act_any = -99, mrs = -99, up = -1, wake = -1, refs = 0, brst = 0, run = 0;
    int act[4] = '{-99, -99, -99, -99};
    int pre[4] = '{-99, -99, -99, -99};
    bit sr = 0, mrs_ok = 0, ck_q = 0, sr_out = 0;
    initial o_viol = 0;
    function automatic int d(int t);
        return (cyc - t) * T_CK_PS;
    endfunction
    task automatic chk(bit ok);
        if (!ok) o_viol++;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (i_cke && !ck_q && up < 0) chk(cyc >= P_PWRUP);
        if (i_cke && !ck_q && up >= 0) wake = cyc;
        if (i_cke && !ck_q) up = cyc;
        if (!i_cke && ck_q && i_cmd == CMD_REF) chk(brst >= P_BURST);
        if (!i_cke && ck_q && i_cmd == CMD_REF)
        begin
            sr = 1;
            sr_out = 1;
            brst = 0;
        end
        if (i_cke && mrs_ok) run++;
        chk(run * T_CK_PS / 1000 <= (refs + 2) * T_REFI_NS);
        if (i_cke && i_cmd != CMD_NOP)
        begin
            // A woken device needs the exit time before any command
            chk(wake < 0 || d(wake) >= T_IS_PS + (sr ? T_RC_PS[GRADE] : T_CK_PS));
            wake = -1;
            sr = 0;
            chk(d(mrs) >= T_MRD_PS[GRADE]);
            case (i_cmd)
                CMD_ACT:
                begin
                    chk(mrs_ok && refs >= INIT_REFS);
                    chk(d(act[i_ba]) >= T_RC_PS[GRADE]);
                    chk(d(act_any) >= T_RRD_PS[GRADE]);
                    chk(d(pre[i_ba]) >= T_RP_PS[GRADE]);
                    act[i_ba] = cyc;
                    act_any = cyc;
                    chk(!sr_out || brst >= P_BURST);
                    sr_out = 0;
                    brst = 0;
                end
                CMD_RD, CMD_WR: chk(d(act[i_ba]) >= T_RCD_PS[GRADE]);
                CMD_PRE:
                    for (int i = 0; i < 4; i++)
                        if (i_addr[AP_BIT] || i == i_ba)
                        begin
                            if (act[i] > pre[i]) chk(d(act[i]) >= T_RAS_PS[GRADE]);
                            if (act[i] > pre[i]) chk(d(act[i]) <= T_RAS_MAX_NS * 1000);
                            pre[i] = cyc;
                        end
                CMD_REF:
                begin
                    for (int i = 0; i < 4; i++) chk(d(pre[i]) >= T_RP_PS[GRADE]);
                    refs++;
                    brst++;
                end
                CMD_MRS:
                begin
                    chk((i_addr[6:4] == 3'h2 && T_CK_PS >= T_CK_CL2_PS)
                        || (i_addr[6:4] == 3'h3 && T_CK_PS >= T_CK_CL3_PS[GRADE]));
                    mrs = cyc;
                    mrs_ok = 1;
                end
                default: ;
            endcase
        end
        ck_q = i_cke;
    end
endmodule // sdc_sdram_model

// ===== tb/sdc_ctrl_tb.sv
// Testbench for the SDRAM command sequencer with a pin-level device model.
// Assumes the shortened power-up and burst counts set below.
`timescale 1ns/1ps
module sdc_ctrl_tb;
    import sdc_pkg::*;
    logic clk = 0, rst = 1, req = 0, we = 0, pd = 0, sr = 0, ack, done, cke, cs_n, ras_n;
    logic cas_n, we_n, dqm;
    logic [1:0] bank = 0, ba;
    logic [12:0] row = 0, addr;
    logic [8:0] col = 0;
    int num_errors = 0, total_checks = 0, cyc = 0, viol;
    sdc_ctrl #(.P_PWRUP_CYC(50), .P_RAS_MAX_CYC(100), .P_SR_BURST(4)) dut (.i_sys_clk(clk),
        .i_sys_rst(rst), .i_req(req), .i_req_we(we), .i_req_bank(bank), .i_req_row(row),
        .i_req_col(col), .o_req_ack(ack), .o_init_done(done), .i_pd_req(pd), .i_sr_req(sr),
        .o_sd_cke(cke), .o_sd_cs_n(cs_n), .o_sd_ras_n(ras_n), .o_sd_cas_n(cas_n),
        .o_sd_we_n(we_n), .o_sd_ba(ba), .o_sd_addr(addr), .o_sd_dqm(dqm));
    sdc_sdram_model #(.P_PWRUP(50), .P_BURST(4)) model (.i_clk(clk), .i_cke(cke),
        .i_cmd({cs_n, ras_n, cas_n, we_n}), .i_ba(ba), .i_addr(addr), .o_viol(viol));
    always #5 clk = ~clk;
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Ceiling well above the roughly 2300 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000) num_errors++;
        if (cyc == 20000) report_and_stop;
    end
    task automatic cmp(string n, logic [12:0] e, logic [12:0] s);
        total_checks++;
        if (s !== e) num_errors++;
        if (s !== e) $display("[FAIL] %s expected %h seen %h", n, e, s);
    endtask
    task automatic t_access(logic w, logic [1:0] b, logic [8:0] c);
        we = w;
        bank = b;
        row = {11'h0, b};
        col = c;
        req = 1;
        for (int i = 0; i < 500 && ack !== 1'b1; i++) @(negedge clk);
        cmp("ack", 13'h1, {12'h0, ack});
        cmp("cmd", {9'h0, w ? CMD_WR : CMD_RD}, {9'h0, cs_n, ras_n, cas_n, we_n});
        cmp("bank", {11'h0, b}, {11'h0, ba});
        cmp("col", {4'h0, c}, {4'h0, addr[8:0]});
        req = 0;
        @(negedge clk);
    endtask
    task automatic t_power(logic deep);
        pd = !deep;
        sr = deep;
        for (int i = 0; i < 500 && cke !== 1'b0; i++) @(negedge clk);
        cmp("cke_low", 13'h0, {12'h0, cke});
        repeat (20) @(negedge clk);
        pd = 0;
        sr = 0;
        t_access(1, 2, 9'h1ff);
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
        cmp("init_done", 13'h1, {12'h0, done});
        cmp("dqm", 13'h0, {12'h0, dqm});
        for (int i = 0; i < 8; i++) t_access(i[0], i[2:1], i[8:0]);
        t_power(0);
        t_power(1);
        // Back-to-back traffic so refreshes must win against new activations
        for (int i = 0; i < 200; i++) t_access(0, 1, 9'h2);
        cmp("violations", 13'h0, viol[12:0]);
        report_and_stop;
    end
endmodule // sdc_ctrl_tb
